//--- core/qbx_expander.sv
`timescale 1ns/1ps
`default_nettype none
module qbx_expander
    import qbx_pkg::*;
#(
    parameter int LINES = QBX_LINES
) (
    input wire logic mclk,
    input wire logic rst,
    qbx_link_if.dev link,
    input wire logic [2:0] addr_select_pins,
    input wire logic [7:0] low_group_lines_in,
    input wire logic [7:0] high_group_lines_in,
    output logic [7:0] low_group_lines_oe_n,
    output logic [7:0] high_group_lines_oe_n,
    output logic [LINES-1:0] weak_pullup_source,
    output logic [LINES-1:0] strong_pullup
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic scl_s1_reg, scl_s2_reg, scl_d_reg;
    logic sda_s1_reg, sda_s2_reg, sda_d_reg;
    logic [2:0] sel_s1_reg, sel_s2_reg;
    logic [LINES-1:0] lin_s1_reg, lin_s2_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            sel_s1_reg <= 3'h0;
            sel_s2_reg <= 3'h0;
            lin_s1_reg <= QBX_PORT_RESET;
            lin_s2_reg <= QBX_PORT_RESET;
        end else begin
            scl_s1_reg <= link.scl;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg <= scl_s2_reg;
            sda_s1_reg <= link.sda;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg <= sda_s2_reg;
            sel_s1_reg <= addr_select_pins;
            sel_s2_reg <= sel_s1_reg;
            lin_s1_reg <= {high_group_lines_in, low_group_lines_in};
            lin_s2_reg <= lin_s1_reg;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s2_reg && !scl_d_reg;
    assign scl_fall = !scl_s2_reg && scl_d_reg;
    // start and stop are SDA edges while SCL stays high
    assign bus_start = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
    assign bus_stop = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;

    // ----------------------------------------
    // serial slave state machine
    // ----------------------------------------
    qbx_dev_state_type state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] low_hold_reg;
    logic rw_reg;
    logic hi_byte_reg;
    logic sda_oe_n_reg;
    logic addr_hit;
    logic [7:0] next_tx_byte;

    assign addr_hit = (shift_reg[7:1] == {QBX_ADDR_FIXED, sel_s2_reg})
        && (shift_reg[7:1] != QBX_GENERAL_CALL);
    // pair order: the byte after a low byte is the high byte
    assign next_tx_byte = hi_byte_reg ? lin_s2_reg[7:0] : lin_s2_reg[15:8];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= QBX_D_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            low_hold_reg <= 8'h00;
            rw_reg <= QBX_DIR_WRITE;
            hi_byte_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end else if (bus_stop) begin
            state_reg <= QBX_D_IDLE;
            sda_oe_n_reg <= 1'b1;
        end else if (bus_start) begin
            state_reg <= QBX_D_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_n_reg <= 1'b1;
        end else begin
            case (state_reg)
                QBX_D_ADDR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s2_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == QBX_BYTE_BITS) begin
                        bit_cnt_reg <= 4'h0;
                        if (addr_hit) begin
                            state_reg <= QBX_D_ACK_A;
                            sda_oe_n_reg <= 1'b0;
                            rw_reg <= shift_reg[0];
                        end else begin
                            state_reg <= QBX_D_SKIP;
                        end
                    end
                end
                QBX_D_ACK_A: begin
                    if (scl_fall) begin
                        hi_byte_reg <= 1'b0;
                        if (rw_reg == QBX_DIR_READ) begin
                            shift_reg <= lin_s2_reg[7:0];
                            sda_oe_n_reg <= lin_s2_reg[7];
                            state_reg <= QBX_D_TX;
                        end else begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= QBX_D_RX;
                        end
                    end
                end
                QBX_D_RX: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s2_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == QBX_BYTE_BITS) begin
                        bit_cnt_reg <= 4'h0;
                        sda_oe_n_reg <= 1'b0;
                        state_reg <= QBX_D_ACK_RX;
                        if (!hi_byte_reg) begin
                            low_hold_reg <= shift_reg;
                        end
                    end
                end
                QBX_D_ACK_RX: begin
                    if (scl_fall) begin
                        sda_oe_n_reg <= 1'b1;
                        hi_byte_reg <= !hi_byte_reg;
                        state_reg <= QBX_D_RX;
                    end
                end
                QBX_D_TX: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == QBX_BYTE_BITS) begin
                            bit_cnt_reg <= 4'h0;
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= QBX_D_ACK_TX;
                        end else begin
                            sda_oe_n_reg <= shift_reg[6];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        end
                    end
                end
                QBX_D_ACK_TX: begin
                    if (scl_rise && sda_s2_reg) begin
                        state_reg <= QBX_D_SKIP;
                    end else if (scl_fall) begin
                        hi_byte_reg <= !hi_byte_reg;
                        shift_reg <= next_tx_byte;
                        sda_oe_n_reg <= next_tx_byte[7];
                        state_reg <= QBX_D_TX;
                    end
                end
                default: begin
                    sda_oe_n_reg <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // port latch and strong pull-up
    // ----------------------------------------
    logic [LINES-1:0] port_reg;
    logic [LINES-1:0] pullup_reg;
    logic pair_done;

    // lines change only at the rise of the high byte's acknowledge clock
    assign pair_done = (state_reg == QBX_D_ACK_RX) && hi_byte_reg && scl_rise;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            port_reg <= QBX_PORT_RESET;
            pullup_reg <= '0;
        end else if (pair_done) begin
            port_reg <= {shift_reg, low_hold_reg};
            pullup_reg <= {shift_reg, low_hold_reg};
        end else if (scl_fall) begin
            pullup_reg <= '0;
        end
    end

    // a line is pulled low only where a zero is latched; a one leaves it
    // on the weak source and usable as an input
    assign low_group_lines_oe_n = port_reg[7:0];
    assign high_group_lines_oe_n = port_reg[15:8];
    assign weak_pullup_source = port_reg;
    assign strong_pullup = pullup_reg;

    // ----------------------------------------
    // change alert
    // ----------------------------------------
    logic [LINES-1:0] ref_reg;
    logic alert_oe_n_reg;
    logic alert_clear;
    logic changed;

    // reads clear after the ack rise, writes after the ack fall
    assign alert_clear = (((state_reg == QBX_D_ACK_A) && rw_reg) && scl_rise)
        || ((state_reg == QBX_D_ACK_TX) && scl_rise)
        || ((state_reg == QBX_D_ACK_RX) && scl_fall);
    // only lines holding a one act as inputs
    assign changed = |((lin_s2_reg ^ ref_reg) & port_reg);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ref_reg <= QBX_PORT_RESET;
            alert_oe_n_reg <= 1'b1;
        end else if (alert_clear) begin
            // an edge landing in this very cycle is absorbed by the snapshot
            ref_reg <= lin_s2_reg;
            alert_oe_n_reg <= 1'b1;
        end else begin
            alert_oe_n_reg <= !changed;
        end
    end

    assign link.alert_oe_n = alert_oe_n_reg;
    assign link.alert_o = 1'b0;
    assign link.sda_d_oe_n = sda_oe_n_reg;
    assign link.sda_d_o = 1'b0;
endmodule // qbx_expander
`default_nettype wire

//--- core/qbx_pkg.sv
package qbx_pkg;
    // ----------------------------------------
    // port geometry and reset state
    // ----------------------------------------
    localparam int QBX_LINES = 16;
    localparam int QBX_GROUP = 8;
    localparam logic [15:0] QBX_PORT_RESET = 16'hffff;
    // ----------------------------------------
    // serial framing
    // ----------------------------------------
    localparam logic [3:0] QBX_ADDR_FIXED = 4'h4;
    localparam logic [6:0] QBX_GENERAL_CALL = 7'h00;
    localparam logic [3:0] QBX_BYTE_BITS = 4'h8;
    localparam logic QBX_DIR_WRITE = 1'b0;
    localparam logic QBX_DIR_READ = 1'b1;
    localparam logic [4:0] QBX_ACK_ADDR = 5'h08;
    localparam logic [4:0] QBX_ACK_LOW = 5'h11;
    localparam logic [4:0] QBX_ACK_HIGH = 5'h1a;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int QBX_MCLK_HZ = 25_000_000;
    localparam int QBX_SCL_HZ = 100_000;
    localparam int QBX_QTR_CYCLES = QBX_MCLK_HZ / (4 * QBX_SCL_HZ);
    // ----------------------------------------
    // state machines
    // ----------------------------------------
    typedef enum logic [7:0] {
        QBX_D_IDLE = 8'h01,
        QBX_D_ADDR = 8'h02,
        QBX_D_ACK_A = 8'h04,
        QBX_D_RX = 8'h08,
        QBX_D_ACK_RX = 8'h10,
        QBX_D_TX = 8'h20,
        QBX_D_ACK_TX = 8'h40,
        QBX_D_SKIP = 8'h80
    } qbx_dev_state_type;
    typedef enum logic [3:0] {
        QBX_H_IDLE = 4'h1,
        QBX_H_START = 4'h2,
        QBX_H_BIT = 4'h4,
        QBX_H_STOP = 4'h8
    } qbx_host_state_type;
endpackage

//--- core/qbx_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface qbx_link_if;
    logic scl_o;
    logic scl_oe_n;
    logic sda_m_o;
    logic sda_m_oe_n;
    logic sda_d_o;
    logic sda_d_oe_n;
    logic alert_o;
    logic alert_oe_n;
    logic scl;
    logic sda;
    logic alert_n;
    // ----------------------------------------
    // wired-and resolution with external pull-ups
    // ----------------------------------------
    assign scl = !(!scl_oe_n && !scl_o);
    assign sda = !((!sda_m_oe_n && !sda_m_o) || (!sda_d_oe_n && !sda_d_o));
    assign alert_n = !(!alert_oe_n && !alert_o);
    modport dev (input scl, input sda, output sda_d_o, output sda_d_oe_n,
        output alert_o, output alert_oe_n);
    modport host (output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n,
        input scl, input sda, input alert_n);
endinterface
`default_nettype wire

//--- core/qbx_master.sv
`timescale 1ns/1ps
`default_nettype none
module qbx_master
    import qbx_pkg::*;
#(
    parameter int QTR_CYCLES = QBX_QTR_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    qbx_link_if.host link,
    input wire logic cmd_valid,
    input wire logic cmd_rw,
    input wire logic [6:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic rsp_nack,
    output logic [15:0] rsp_rdata,
    output logic alert_n
);
    // ----------------------------------------
    // bus sampling
    // ----------------------------------------
    logic sda_s1_reg, sda_s2_reg, al_s1_reg, al_s2_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            al_s1_reg <= 1'b1;
            al_s2_reg <= 1'b1;
        end else begin
            sda_s1_reg <= link.sda;
            sda_s2_reg <= sda_s1_reg;
            al_s1_reg <= link.alert_n;
            al_s2_reg <= al_s1_reg;
        end
    end
    assign alert_n = al_s2_reg;

    // ----------------------------------------
    // quarter-bit divider; SCL is made here, not sampled
    // ----------------------------------------
    logic [15:0] qcnt_reg;
    logic tick;
    assign tick = (qcnt_reg == 16'(QTR_CYCLES - 1));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            qcnt_reg <= 16'h0000;
        end else if (tick) begin
            qcnt_reg <= 16'h0000;
        end else begin
            qcnt_reg <= qcnt_reg + 16'h0001;
        end
    end

    // ----------------------------------------
    // transfer sequencer: one byte pair per command
    // ----------------------------------------
    qbx_host_state_type state_reg;
    logic [1:0] phase_reg;
    logic [4:0] bit_idx_reg;
    logic [26:0] frame_reg;
    logic [15:0] rx_reg;
    logic rw_reg, nack_reg, scl_oe_n_reg, sda_oe_n_reg;
    logic ack_slot;
    assign ack_slot = (bit_idx_reg == QBX_ACK_ADDR) || (bit_idx_reg == QBX_ACK_LOW)
        || (bit_idx_reg == QBX_ACK_HIGH);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= QBX_H_IDLE;
            phase_reg <= 2'h0;
            bit_idx_reg <= 5'h00;
            frame_reg <= '1;
            rx_reg <= 16'h0000;
            rw_reg <= QBX_DIR_WRITE;
            nack_reg <= 1'b0;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_nack <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= 1'b0;
            case (state_reg)
                QBX_H_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        rw_reg <= cmd_rw;
                        nack_reg <= 1'b0;
                        phase_reg <= 2'h0;
                        state_reg <= QBX_H_START;
                        // read: release data bits, ack low byte, nack high byte
                        if (cmd_rw == QBX_DIR_READ) begin
                            frame_reg <= {cmd_addr, cmd_rw, 1'b1, 8'hff, 1'b0, 8'hff, 1'b1};
                        end else begin
                            frame_reg <= {cmd_addr, cmd_rw, 1'b1, cmd_wdata[7:0], 1'b1,
                                cmd_wdata[15:8], 1'b1};
                        end
                    end
                end
                QBX_H_START: begin
                    if (tick) begin
                        phase_reg <= phase_reg + 2'h1;
                        if (phase_reg == 2'h1) begin
                            sda_oe_n_reg <= 1'b0;
                        end else if (phase_reg == 2'h3) begin
                            scl_oe_n_reg <= 1'b0;
                            bit_idx_reg <= 5'h00;
                            state_reg <= QBX_H_BIT;
                        end
                    end
                end
                QBX_H_BIT: begin
                    if (tick) begin
                        phase_reg <= phase_reg + 2'h1;
                        if (phase_reg == 2'h0) begin
                            sda_oe_n_reg <= frame_reg[26];
                        end else if (phase_reg == 2'h1) begin
                            scl_oe_n_reg <= 1'b1;
                        end else if (phase_reg == 2'h2) begin
                            if (ack_slot && (bit_idx_reg == QBX_ACK_ADDR || !rw_reg)) begin
                                nack_reg <= sda_s2_reg;
                            end else if (rw_reg && !ack_slot && bit_idx_reg > QBX_ACK_ADDR) begin
                                rx_reg <= {rx_reg[14:0], sda_s2_reg};
                            end
                        end else begin
                            scl_oe_n_reg <= 1'b0;
                            frame_reg <= {frame_reg[25:0], 1'b1};
                            bit_idx_reg <= bit_idx_reg + 5'h01;
                            if (nack_reg || bit_idx_reg == QBX_ACK_HIGH) begin
                                state_reg <= QBX_H_STOP;
                            end
                        end
                    end
                end
                default: begin
                    if (tick) begin
                        phase_reg <= phase_reg + 2'h1;
                        if (phase_reg == 2'h0) begin
                            sda_oe_n_reg <= 1'b0;
                        end else if (phase_reg == 2'h1) begin
                            scl_oe_n_reg <= 1'b1;
                        end else if (phase_reg == 2'h2) begin
                            sda_oe_n_reg <= 1'b1;
                        end else begin
                            state_reg <= QBX_H_IDLE;
                            cmd_ready <= 1'b1;
                            rsp_valid <= 1'b1;
                            rsp_nack <= nack_reg;
                            rsp_rdata <= {rx_reg[7:0], rx_reg[15:8]};
                        end
                    end
                end
            endcase
        end
    end

    assign link.scl_oe_n = scl_oe_n_reg;
    assign link.scl_o = 1'b0;
    assign link.sda_m_oe_n = sda_oe_n_reg;
    assign link.sda_m_o = 1'b0;
endmodule // qbx_master
`default_nettype wire

//--- testbench/qbx_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module qbx_link_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_d_oe_n,
    input wire logic alert_oe_n
);
    logic busy_reg;
    logic sda_prev_reg;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // bus busy from start to stop
    // ----------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sda_prev_reg <= 1'b1;
        end else begin
            sda_prev_reg <= sda;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
        end else if (scl && sda_prev_reg && !sda) begin
            busy_reg <= 1'b1;
        end else if (scl && !sda_prev_reg && sda) begin
            busy_reg <= 1'b0;
        end
    end
    // ----------------------------------------
    // device side of the wire
    // ----------------------------------------
    sequence s_dev_grab;
        $fell(sda_d_oe_n);
    endsequence
    sequence s_scl_fall_soon;
        ##[1:200] $fell(scl);
    endsequence
    a_dev_sda_steady: assert property (scl && $past(scl) |-> $stable(sda_d_oe_n))
        else $error("expander changed sda while scl high");
    a_grab_in_low: assert property (s_dev_grab |-> !scl)
        else $error("expander pulled sda while scl high");
    a_ack_hold_high: assert property (s_dev_grab |-> !sda_d_oe_n throughout s_scl_fall_soon)
        else $error("expander let go of sda before the clock pulse ended");
    a_release_in_low: assert property ($rose(sda_d_oe_n) |-> !scl)
        else $error("expander released sda while scl high");
    a_start_by_host: assert property (scl && $fell(sda) |-> sda_d_oe_n)
        else $error("start condition made by the expander");
    a_stop_free_sda: assert property (scl && $rose(sda) |-> sda_d_oe_n && $past(sda_d_oe_n))
        else $error("expander still held sda at stop");
    a_idle_quiet: assert property (!busy_reg |-> sda_d_oe_n)
        else $error("expander drove sda on an idle bus");
    a_reset_quiet: assert property ($fell(rst) |-> (sda_d_oe_n && alert_oe_n) [*3])
        else $error("expander not quiet after reset");
endmodule // qbx_link_checker
`default_nettype wire

//--- testbench/qbx_expander_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module qbx_expander_bench;
    import qbx_pkg::*;
    localparam int QTR = 10;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_rw = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [2:0] addr_select_pins = 3'h0;
    logic [15:0] ext_level = 16'hffff;
    logic [15:0] seen_strong = 16'h0000;
    logic [7:0] lo_oe_n, hi_oe_n;
    logic [15:0] weak_src, strong_pu, rsp_rdata, v;
    logic cmd_ready, rsp_valid, rsp_nack, alert_n;
    int num_errors = 0;
    int n_tests = 0;
    int seed = 15264;
    int cycles = 0;
    qbx_link_if link ();
    // quasi-bidirectional pins: a driven low wins over the outside world
    qbx_expander i_qbx_expander (.mclk(mclk), .rst(rst), .link(link),
        .addr_select_pins(addr_select_pins), .low_group_lines_in(lo_oe_n & ext_level[7:0]),
        .high_group_lines_in(hi_oe_n & ext_level[15:8]), .low_group_lines_oe_n(lo_oe_n),
        .high_group_lines_oe_n(hi_oe_n), .weak_pullup_source(weak_src), .strong_pullup(strong_pu));
    qbx_master #(.QTR_CYCLES(QTR)) i_qbx_master (.mclk(mclk), .rst(rst), .link(link),
        .cmd_valid(cmd_valid), .cmd_rw(cmd_rw), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
        .rsp_rdata(rsp_rdata), .alert_n(alert_n));
    qbx_link_checker i_qbx_link_checker (.mclk(mclk), .rst(rst), .scl(link.scl),
        .sda(link.sda), .sda_d_oe_n(link.sda_d_oe_n), .alert_oe_n(link.alert_oe_n));
    // ----------------------------------------
    // clock, watchdog, strong pull-up monitor
    // ----------------------------------------
    initial begin
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        seen_strong <= seen_strong | strong_pu;
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            final_report();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [6:0] dev_addr(input logic [2:0] pins);
        return {QBX_ADDR_FIXED, pins};
    endfunction
    task automatic xfer(input logic rw, input logic [6:0] addr, input logic [15:0] wd);
        int k;
        @(negedge mclk);
        seen_strong = 16'h0000;
        cmd_rw = rw;
        cmd_addr = addr;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++) @(negedge mclk);
        if (rsp_valid !== 1'b1) begin
            num_errors++;
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        `CHK("lines oe_n", 16'hffff, {hi_oe_n, lo_oe_n})
        `CHK("weak source", QBX_PORT_RESET, weak_src)
        `CHK("strong pull-up", 16'h0000, strong_pu)
        `CHK("alert idle", 1'b1, alert_n)
        `CHK("master ready", 1'b1, cmd_ready)
        // every select-pin setting with a random pair
        for (int p = 0; p < 8; p++) begin
            addr_select_pins = p[2:0];
            v = 16'($random(seed));
            xfer(1'b0, dev_addr(p[2:0]), v);
            `CHK("write ack", 1'b0, rsp_nack)
            `CHK("port value", v, weak_src)
            `CHK("low group drive", v[7:0], lo_oe_n)
            `CHK("high group drive", v[15:8], hi_oe_n)
            `CHK("strong pulse", v, seen_strong)
        end
        xfer(1'b0, dev_addr(~addr_select_pins), 16'h0000);
        `CHK("foreign nack", 1'b1, rsp_nack)
        `CHK("foreign keeps port", v, weak_src)
        xfer(1'b0, QBX_GENERAL_CALL, 16'h0000);
        `CHK("general call nack", 1'b1, rsp_nack)
        `CHK("general call keeps port", v, weak_src)
        // inputs need ones written first, else the pins read back low
        xfer(1'b0, dev_addr(addr_select_pins), 16'hffff);
        // bit 0 forced low so the read always has an alert to clear
        ext_level = 16'($random(seed)) & 16'hfffe;
        repeat (12) @(negedge mclk);
        `CHK("alert before read", 1'b0, alert_n)
        xfer(1'b1, dev_addr(addr_select_pins), 16'h0000);
        `CHK("read ack", 1'b0, rsp_nack)
        `CHK("read data", ext_level, rsp_rdata)
        repeat (12) @(negedge mclk);
        `CHK("alert after read", 1'b1, alert_n)
        ext_level[3] = ~ext_level[3];
        repeat (12) @(negedge mclk);
        `CHK("alert on edge", 1'b0, alert_n)
        ext_level[3] = ~ext_level[3];
        repeat (12) @(negedge mclk);
        `CHK("alert on restore", 1'b1, alert_n)
        ext_level[12] = ~ext_level[12];
        repeat (12) @(negedge mclk);
        `CHK("alert again", 1'b0, alert_n)
        xfer(1'b0, dev_addr(~addr_select_pins), 16'h0000);
        `CHK("alert kept by foreign", 1'b0, alert_n)
        xfer(1'b0, dev_addr(addr_select_pins), 16'hffff);
        repeat (12) @(negedge mclk);
        `CHK("alert cleared by write", 1'b1, alert_n)
        final_report();
    end
endmodule // qbx_expander_bench
`default_nettype wire
